// >>> logic/sfxalu_cfg.svh
// Constants of the saturating fixed-point datapath: limits, shifts, fields.
// Assumes inclusion by bare name from the design files.
`ifndef SFXALU_CFG_SVH
`define SFXALU_CFG_SVH

// Saturation limits of short and long words
`define SFX_MAX16 16'h7fff
`define SFX_MIN16 16'h8000
`define SFX_MAX32 32'h7fffffff
`define SFX_MIN32 32'h80000000

// Scaled product: rounding constant and scale shift
`define SFX_ROUND 32'h00004000
`define SFX_MULT_SHIFT 15

// Input word masking
`define SFX_SAMPLE_LSBS 3
`define SFX_PARAM_W_LSB 0
`define SFX_PARAM_W_MSB 2

// Quotient steps and shift clamp
`define SFX_DIV_STEPS 15
`define SFX_SHIFT_LIMIT 17'h00020

// Compare result field positions
`define SFX_CMP_LT 0
`define SFX_CMP_EQ 1
`define SFX_CMP_GT 2

// Reset value of the result register
`define SFX_RES_RST 32'h00000000

`endif

// >>> logic/sfxalu_pkg.sv
// Types shared by the saturating fixed-point datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package sfxalu_pkg;

    // Operation select presented with each request
    typedef enum logic [4:0] {
        OP_ADD,
        OP_SUB,
        OP_MULT,
        OP_MULT_R,
        OP_ABS,
        OP_DIV,
        OP_L_MULT,
        OP_L_ADD,
        OP_L_SUB,
        OP_NORM,
        OP_SHL,
        OP_SHR,
        OP_L_SHL,
        OP_L_SHR,
        OP_EXT,
        OP_TRUNC,
        OP_MASK_SAMPLE,
        OP_MASK_PARAM,
        OP_CMP,
        OP_L_CMP
    } sfxalu_op_e;

endpackage : sfxalu_pkg

// >>> logic/sfxalu_div.sv
// Fractional quotient of two positive short words, unrolled restoring loop.
// Assumes the caller keeps divisor >= dividend > 0; other inputs give junk.
module sfxalu_div #(
    parameter int WIDTH = 16,
    parameter int STEPS = 15
) (
    // Operands
    input wire logic [WIDTH-1:0] dividend,
    input wire logic [WIDTH-1:0] divisor,
    // Result
    output logic [WIDTH-1:0] quotient
);

    // One quotient bit per step; equal operands give 15 ones, 32767
    always_comb begin
        logic [2*WIDTH-1:0] num;
        logic [2*WIDTH-1:0] den;
        logic [WIDTH-1:0] q;
        num = {{WIDTH{1'b0}}, dividend};
        den = {{WIDTH{1'b0}}, divisor};
        q = '0;
        for (int k = 0; k < STEPS; k++) begin
            q = {q[WIDTH-2:0], 1'b0};
            num = {num[2*WIDTH-2:0], 1'b0};
            if (num >= den) begin // [RL8]
                num = num - den;
                q = q | {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
        quotient = q; // [RL8] leading bit stays zero after 15 steps
    end

endmodule : sfxalu_div

// >>> logic/sfxalu_top.sv
// Saturating fixed-point arithmetic datapath for a speech codec.
// Assumes the sequencing logic on ref_clk issues one operation per strobe.
//
// What this block does, and what its issuer keeps to
// RL1 - Handles only signed 16-bit short and 32-bit long two's complement.
// RL2 - Short addition saturates to +32767 or -32768 instead of wrapping.
// RL3 - Short subtraction saturates to +32767 or -32768 instead of wrapping.
// RL4 - Scaled product is full product shifted right 15; min times min is 32767.
// RL5 - Rounded scaled product adds 16384 before the shift; min squared 32767.
// RL6 - Absolute value of short word, with -32768 giving 32767.
// RL7 - Issuer asks for a quotient only with divisor >= dividend > 0.
// RL8 - Quotient is positive, truncated to 16 bits; equal operands give 32767.
// RL9 - Long doubled product is the 32-bit product shifted left by one.
// RL10 - Issuer never asks for the long doubled product of min by min.
// RL11 - Long addition saturates to 2147483647 or -2147483648.
// RL12 - Long subtraction saturates to 2147483647 or -2147483648.
// RL13 - Shift count brings a long word into its normalized signed range.
// RL14 - Left shift fills zeros; a negative count shifts right instead.
// RL15 - Right shift extends sign; a negative count shifts left instead.
// RL16 - A short word widened to long has its sign copied upward.
// RL17 - A long word narrowed to short keeps its low 16 bits, no saturation.
// RL18 - Constants entering long operations are sign-extended to 32 bits.
// RL19 - Samples use 13 upper bits, parameters only their low valid bits.
// RL20 - Long results stay 32 bits except through the explicit narrowing.
// RL21 - All comparisons are signed at the operand's declared width.
// RL22 - Operation and operands come with a strobe; results pulse in order.
`include "sfxalu_cfg.svh"

module sfxalu_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Request from the sequencing logic
    input wire logic op_valid,
    input wire sfxalu_pkg::sfxalu_op_e op_code,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic op_b_short,
    // Result back to the sequencing logic
    output logic res_valid,
    output logic [31:0] res_data,
    output logic res_sat
);
    import sfxalu_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Widen a short word with its sign copied into the upper half
    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v}; // [RL16]
    endfunction : sext16

    // Clamp a 17-bit short sum to the short range
    function automatic logic [31:0] sat16(input logic [16:0] s);
        if (s[16] == s[15]) begin
            sat16 = sext16(s[15:0]);
        end else if (s[16]) begin
            sat16 = sext16(`SFX_MIN16); // [RL2] [RL3]
        end else begin
            sat16 = sext16(`SFX_MAX16); // [RL2] [RL3]
        end
    endfunction : sat16

    // Clamp a 33-bit long sum to the long range
    function automatic logic [31:0] sat32(input logic [32:0] s);
        if (s[32] == s[31]) begin
            sat32 = s[31:0];
        end else if (s[32]) begin
            sat32 = `SFX_MIN32; // [RL11] [RL12]
        end else begin
            sat32 = `SFX_MAX32; // [RL11] [RL12]
        end
    endfunction : sat32

    // Shift with signed count; a negative count turns the direction round.
    // Counts of 32 or more clear the word or fill it with its sign.
    function automatic logic [31:0] shift_long(
        input logic [31:0] x,
        input logic [15:0] n,
        input logic to_left
    );
        logic [16:0] mag;
        logic left;
        mag = n[15] ? 17'(-$signed({n[15], n})) : {1'b0, n};
        left = to_left ^ n[15]; // [RL14] [RL15]
        if (left) begin
            shift_long = (mag >= `SFX_SHIFT_LIMIT) ? 32'h00000000 : x << mag;
        end else if (mag >= `SFX_SHIFT_LIMIT) begin
            shift_long = {32{x[31]}}; // [RL15]
        end else begin
            shift_long = 32'($signed(x) >>> mag); // [RL15]
        end
    endfunction : shift_long

    // Left shifts that bring a long word into its normalized range
    function automatic logic [4:0] norm32(input logic [31:0] x);
        logic [4:0] cnt;
        logic run;
        cnt = 5'h00;
        run = (x != 32'h00000000);
        for (int i = 30; i >= 0; i--) begin
            if (run && (x[i] == x[31])) begin
                cnt = cnt + 5'h01; // [RL13]
            end else begin
                run = 1'b0;
            end
        end
        norm32 = cnt;
    endfunction : norm32

    // Signed three-way compare packed into the compare field
    function automatic logic [31:0] cmp_word(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic [31:0] w;
        w = 32'h00000000;
        w[`SFX_CMP_LT] = $signed(a) < $signed(b); // [RL21]
        w[`SFX_CMP_EQ] = (a == b); // [RL21]
        w[`SFX_CMP_GT] = $signed(a) > $signed(b); // [RL21]
        cmp_word = w;
    endfunction : cmp_word

    // ------------------------------------------------------------
    // Operand preparation
    // ------------------------------------------------------------

    logic [15:0] a16;
    logic [15:0] b16;
    logic [31:0] b_long;
    logic [31:0] prod;
    logic [31:0] prod_r;
    logic min_sq;
    logic [15:0] div_q;
    logic [15:0] pmask;
    logic [31:0] result_next;
    logic sat_next;

    // Short ops see only the low half of each operand
    assign a16 = op_a[15:0]; // [RL1]
    assign b16 = op_b[15:0]; // [RL1]
    // A short constant headed for a long op is widened with its sign
    assign b_long = op_b_short ? sext16(b16) : op_b; // [RL18]

    // Full signed product; it never exceeds 2^30 so 32 bits hold it
    assign prod = $signed(sext16(a16)) * $signed(sext16(b16));
    assign prod_r = prod + `SFX_ROUND; // [RL5]
    assign min_sq = (a16 == `SFX_MIN16) && (b16 == `SFX_MIN16);
    // Valid low bits of a coded parameter, width from op_b
    assign pmask = 16'((17'h00001 << op_b[`SFX_PARAM_W_MSB:`SFX_PARAM_W_LSB])
        - 17'h00001);

    // Quotient: combinational, so every op keeps the same latency
    sfxalu_div #(
        .WIDTH(16),
        .STEPS(`SFX_DIV_STEPS)
    ) u_div (
        .dividend(a16), // [RL7] caller keeps operands in range
        .divisor(b16),
        .quotient(div_q)
    );

    // ------------------------------------------------------------
    // Operation select
    // ------------------------------------------------------------

    // Short results return sign-extended; long ones keep all 32 bits
    always_comb begin
        result_next = 32'h00000000;
        sat_next = 1'b0;
        unique case (op_code)
            OP_ADD: begin
                result_next = sat16({a16[15], a16} + {b16[15], b16}); // [RL2]
                sat_next = (result_next[15:0] != 16'(a16 + b16));
            end
            OP_SUB: begin
                result_next = sat16({a16[15], a16} - {b16[15], b16}); // [RL3]
                sat_next = (result_next[15:0] != 16'(a16 - b16));
            end
            OP_MULT: begin
                // [RL4] min squared would give +32768, one past the top
                result_next = min_sq ? sext16(`SFX_MAX16)
                    : sext16(prod[30:15]); // [RL4]
                sat_next = min_sq;
            end
            OP_MULT_R: begin
                result_next = min_sq ? sext16(`SFX_MAX16)
                    : sext16(prod_r[30:15]); // [RL5]
                sat_next = min_sq;
            end
            OP_ABS: begin
                if (a16 == `SFX_MIN16) begin
                    result_next = sext16(`SFX_MAX16); // [RL6]
                    sat_next = 1'b1;
                end else begin
                    result_next = a16[15] ? sext16(16'(-a16)) : sext16(a16);
                end
            end
            OP_DIV: begin
                result_next = {16'h0000, div_q}; // [RL8]
            end
            OP_L_MULT: begin
                // Min by min wraps here; the issuer never asks for it
                result_next = {prod[30:0], 1'b0}; // [RL9] [RL10]
            end
            OP_L_ADD: begin
                result_next = sat32({op_a[31], op_a} + {b_long[31], b_long});
                sat_next = (result_next != 32'(op_a + b_long)); // [RL11]
            end
            OP_L_SUB: begin
                result_next = sat32({op_a[31], op_a} - {b_long[31], b_long});
                sat_next = (result_next != 32'(op_a - b_long)); // [RL12]
            end
            OP_NORM: begin
                result_next = {27'h0000000, norm32(op_a)}; // [RL13]
            end
            OP_SHL: begin
                result_next = sext16(16'(shift_long(sext16(a16), b16,
                    1'b1))); // [RL14]
            end
            OP_SHR: begin
                result_next = sext16(16'(shift_long(sext16(a16), b16,
                    1'b0))); // [RL15]
            end
            OP_L_SHL: begin
                result_next = shift_long(op_a, b16, 1'b1); // [RL14] [RL20]
            end
            OP_L_SHR: begin
                result_next = shift_long(op_a, b16, 1'b0); // [RL15] [RL20]
            end
            OP_EXT: begin
                result_next = sext16(a16); // [RL16]
            end
            OP_TRUNC: begin
                // The only path that narrows a long word
                result_next = sext16(op_a[15:0]); // [RL17] [RL20]
            end
            OP_MASK_SAMPLE: begin
                result_next = sext16({a16[15:`SFX_SAMPLE_LSBS],
                    `SFX_SAMPLE_LSBS'(0)}); // [RL19]
            end
            OP_MASK_PARAM: begin
                result_next = {16'h0000, a16 & pmask}; // [RL19]
            end
            OP_CMP: begin
                result_next = cmp_word(sext16(a16), sext16(b16)); // [RL21]
            end
            OP_L_CMP: begin
                result_next = cmp_word(op_a, b_long); // [RL21]
            end
            default: begin
                result_next = 32'h00000000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------

    // Strobe: one result pulse per request, one cycle later
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= op_valid; // [RL22]
        end
    end

    // Data: held until the next request, so order is issue order
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_data <= `SFX_RES_RST;
        end else if (op_valid) begin
            res_data <= result_next; // [RL22] [RL20]
        end
    end

    // Saturation flag travels with its result
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_sat <= 1'b0;
        end else if (op_valid) begin
            res_sat <= sat_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Copy of the last op_a, read only by the checks below
    logic [31:0] chk_a_reg;
    logic [31:0] chk_norm;
    logic [31:0] chk_prod_r;
    always_ff @(posedge ref_clk) begin
        chk_a_reg <= op_a;
    end
    assign chk_norm = chk_a_reg << res_data[4:0];
    assign chk_prod_r = $signed(sext16(a16)) * $signed(sext16(b16))
        + 32'h00004000;

    a_result_strobe: assert property (op_valid |=> res_valid ##1 // [RL22]
        (res_valid == $past(op_valid)))
        else $error("result strobe does not follow request");
    a_idle_quiet: assert property (!op_valid |=> !res_valid) // [RL22]
        else $error("result strobe without request");
    a_add_top_sat: assert property (op_valid && op_code == OP_ADD && // [RL2]
        !a16[15] && !b16[15] && (17'(a16) + 17'(b16)) > 17'h07fff
        |=> res_data == 32'h00007fff && res_sat)
        else $error("short add did not clamp high");
    a_sub_low_sat: assert property (op_valid && op_code == OP_SUB && // [RL3]
        a16 == 16'h8000 && b16 == 16'h0001
        |=> res_data == 32'hffff8000)
        else $error("short sub did not clamp low");
    a_mult_min_sq: assert property (op_valid && op_code == OP_MULT && // [RL4]
        a16 == 16'h8000 && b16 == 16'h8000 |=> res_data == 32'h00007fff)
        else $error("scaled product of min by min wrong");
    a_multr_round: assert property (op_valid && op_code == OP_MULT_R // [RL5]
        && !(a16 == 16'h8000 && b16 == 16'h8000)
        |=> res_data[15:0] == $past(chk_prod_r[30:15]))
        else $error("rounded product wrong");
    a_abs_min: assert property (op_valid && op_code == OP_ABS && // [RL6]
        a16 == 16'h8000 |=> res_data == 32'h00007fff)
        else $error("absolute of min wrong");
    a_div_equal: assert property (op_valid && op_code == OP_DIV && // [RL8]
        a16 == b16 && a16 != 16'h0000 && !a16[15]
        |=> res_data == 32'h00007fff)
        else $error("quotient of equal operands wrong");
    a_ladd_sat: assert property (op_valid && op_code == OP_L_ADD && // [RL11]
        !op_b_short && op_a == 32'h7fffffff && op_b == 32'h00000001
        |=> res_data == 32'h7fffffff)
        else $error("long add did not clamp");
    a_lsub_sat: assert property (op_valid && op_code == OP_L_SUB && // [RL12]
        !op_b_short && op_a == 32'h80000000 && op_b == 32'h00000001
        |=> res_data == 32'h80000000)
        else $error("long sub did not clamp");
    a_norm_range: assert property (op_valid && op_code == OP_NORM && // [RL13]
        op_a != 32'h00000000 |=> chk_norm[31] != chk_norm[30])
        else $error("shift count does not normalize");
    a_trunc_low: assert property (op_valid && op_code == OP_TRUNC // [RL17]
        |=> res_data[15:0] == $past(op_a[15:0]) &&
        res_data[31:16] == {16{res_data[15]}})
        else $error("narrowing lost low half or sign");
    a_sample_lsbs: assert property (op_valid && // [RL19]
        op_code == OP_MASK_SAMPLE |=> res_data[2:0] == 3'h0)
        else $error("sample low bits not cleared");

    // Main scenarios
    c_add_sat: cover property (op_valid && op_code == OP_ADD ##1 res_sat);
    c_div_run: cover property (op_valid && op_code == OP_DIV
        ##1 res_valid && res_data != 32'h00000000);
    c_norm_neg: cover property (op_valid && op_code == OP_NORM && op_a[31]);
    c_back2back: cover property (op_valid [*3]);

endmodule : sfxalu_top

// >>> dv/sfxalu_issuer.sv
// Model of the sequencing logic that issues requests to the datapath.
// Assumes its tasks are called by the bench just after a falling edge.
module sfxalu_issuer (
    // Request to the datapath
    output logic op_valid,
    output sfxalu_pkg::sfxalu_op_e op_code,
    output logic [31:0] op_a,
    output logic [31:0] op_b,
    output logic op_b_short
);
    timeunit 1ns;
    timeprecision 100ps;
    import sfxalu_pkg::*;

    // -----------------------------------------------------------------
    // Request lines
    // -----------------------------------------------------------------
    // Quiet lines from time zero, before reset releases
    initial begin
        op_valid = 1'b0;
        op_code = OP_ADD;
        op_a = 32'h0000_0000;
        op_b = 32'h0000_0000;
        op_b_short = 1'b0;
    end

    // One request; the strobe stays up so the next may follow at once
    task automatic issue(input logic [4:0] op, input logic [31:0] a,
                         input logic [31:0] b, input logic bs);
        op_valid = 1'b1;
        op_code = sfxalu_op_e'(op);
        op_a = a;
        op_b = b;
        op_b_short = bs;
    endtask : issue

    // Drop the strobe; operands flip so a stale value never looks valid
    task automatic idle();
        op_valid = 1'b0;
        op_a = ~op_a;
        op_b = ~op_b;
        op_b_short = ~op_b_short;
    endtask : idle
endmodule : sfxalu_issuer

// >>> dv/tb_top.sv
// Self-checking bench of the saturating fixed-point datapath.
// Assumes one-cycle latency and registered result lines from the design.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sfxalu_pkg::*;

    // -----------------------------------------------------------------
    // Clock, reset and the design
    // -----------------------------------------------------------------
    logic ref_clk;
    logic sys_rst;
    logic op_valid;
    sfxalu_op_e op_code;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic op_b_short;
    logic res_valid;
    logic [31:0] res_data;
    logic res_sat;
    int errors;
    int comparisons;
    int cycles;

    // Free-running codec clock, 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    sfxalu_issuer u_iss (.op_valid(op_valid), .op_code(op_code),
        .op_a(op_a), .op_b(op_b), .op_b_short(op_b_short));

    sfxalu_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .op_valid(op_valid), .op_code(op_code), .op_a(op_a),
        .op_b(op_b), .op_b_short(op_b_short), .res_valid(res_valid),
        .res_data(res_data), .res_sat(res_sat));

    // -----------------------------------------------------------------
    // Expected results, worked out from the arithmetic definitions
    // -----------------------------------------------------------------
    // Clamp to hi and -(hi+1); flag in bit 32
    function automatic logic [32:0] clamp(logic signed [63:0] w,
                                          logic signed [63:0] hi);
        logic signed [63:0] lo;
        lo = -hi - 1;
        if (w > hi) return {1'b1, hi[31:0]};
        if (w < lo) return {1'b1, lo[31:0]};
        return {1'b0, w[31:0]};
    endfunction : clamp

    function automatic logic [32:0] expect_res(logic [4:0] op,
        logic [31:0] a, logic [31:0] b, logic bs);
        logic signed [31:0] x, y, yl, v, r;
        logic signed [63:0] wa, wb;
        logic [31:0] num, q;
        int n;
        x = {{16{a[15]}}, a[15:0]};
        y = {{16{b[15]}}, b[15:0]};
        yl = bs ? y : b;
        wa = $signed(a);
        wb = yl;
        n = y;
        r = 32'h0;
        case (op)
            0: return clamp(x + y, 32767);
            1: return clamp(x - y, 32767);
            2, 3: begin
                if (a[15:0] == 16'h8000 && b[15:0] == 16'h8000)
                    return {1'b1, 32'h0000_7fff};
                r = (x * y + ((op == 3) ? 16384 : 0)) >>> 15;
                r = {{16{r[15]}}, r[15:0]};
            end
            4: begin
                if (a[15:0] == 16'h8000) return {1'b1, 32'h0000_7fff};
                r = (x < 0) ? -x : x;
            end
            5: begin
                num = x;
                q = 0;
                for (int k = 0; k < 15; k++) begin
                    q = q << 1;
                    num = num << 1;
                    if (num >= y) begin
                        num = num - y;
                        q = q + 1;
                    end
                end
                r = q;
            end
            6: r = (x * y) <<< 1;
            7: return clamp(wa + wb, 2147483647);
            8: return clamp(wa - wb, 2147483647);
            9: begin
                v = a[31] ? ~a : a;
                while (a != 0 && v < 32'h4000_0000 && r < 31) begin
                    v = v <<< 1;
                    r = r + 1;
                end
            end
            10, 11, 12, 13: begin
                v = (op >= 12) ? $signed(a) : x;
                if ((op == 10 || op == 12) != (n < 0))
                    r = (n >= 32 || n <= -32) ? 0 : v <<< ((n < 0) ? -n : n);
                else
                    r = (n >= 32 || n <= -32) ? v >>> 31
                                               : v >>> ((n < 0) ? -n : n);
                if (op < 12) r = {{16{r[15]}}, r[15:0]};
            end
            14, 15: r = x;
            16: r = {{16{a[15]}}, a[15:3], 3'b000};
            17: r = {16'h0, a[15:0]} & ((32'h1 << b[2:0]) - 32'h1);
            18: r = {29'h0, x > y, x == y, x < y};
            19: r = {29'h0, $signed(a) > yl, $signed(a) == yl,
                      $signed(a) < yl};
            default: r = 32'h0;
        endcase
        return {1'b0, r};
    endfunction : expect_res

    // -----------------------------------------------------------------
    // Drivers, checks and the verdict
    // -----------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic check(logic ok, string what);
        comparisons++;
        if (!ok) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check

    // Issue at a falling edge; the answer is looked at one cycle on
    task automatic run(logic [4:0] op, logic [31:0] a, logic [31:0] b,
                       logic bs);
        logic [32:0] e;
        e = expect_res(op, a, b, bs);
        u_iss.issue(op, a, b, bs);
        @(negedge ref_clk);
        check(res_valid === 1'b1, "result strobe missing");
        check(res_data === e[31:0] && res_sat === e[32],
              $sformatf("op %0d a %h b %h got %h", op, a, b, res_data));
    endtask : run

    // Cycle ceiling cuts a hang short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            $display("unexpected at %0t: run too long", $time);
            conclude();
        end
    end

    initial begin
        logic [4:0] op;
        logic [31:0] a, b, held;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        sys_rst = 1'b1;
        void'($urandom(32'hd9af3e13));
        repeat (10) @(negedge ref_clk);
        check(res_valid === 1'b0 && res_sat === 1'b0
              && res_data === 32'h0, "reset state");
        sys_rst = 1'b0;
        // Corner cases, back to back with the strobe held up
        run(0, 32'h7fff, 32'h0001, 0);
        run(0, 32'hffff_8000, 32'hffff_ffff, 0);
        run(1, 32'h8000, 32'h0001, 0);
        run(1, 32'h7fff, 32'hffff, 0);
        run(2, 32'h8000, 32'h8000, 0);
        run(2, 32'h4000, 32'hc000, 0);
        run(3, 32'h8000, 32'h8000, 0);
        run(3, 32'h0001, 32'h4000, 0);
        run(4, 32'h8000, 32'h0, 0);
        run(4, 32'hfffb, 32'h0, 0);
        run(5, 32'h1234, 32'h1234, 0);
        run(5, 32'h0001, 32'h7fff, 0);
        run(6, 32'h8000, 32'h7fff, 0);
        run(7, 32'h7fff_ffff, 32'h1, 0);
        run(7, 32'h8000_0000, 32'hffff, 1);
        run(8, 32'h8000_0000, 32'h1, 0);
        run(8, 32'h7fff_ffff, 32'h0000_8000, 1);
        run(9, 32'h0, 32'h0, 0);
        run(9, 32'hffff_ffff, 32'h0, 0);
        run(9, 32'hc000_0000, 32'h0, 0);
        run(9, 32'h0000_0001, 32'h0, 0);
        run(10, 32'h0003, 32'hfffe, 0);
        run(10, 32'h0003, 32'h0028, 0);
        run(12, 32'h8000_0001, 32'hffe0, 0);
        run(11, 32'h8000, 32'h0004, 0);
        run(13, 32'h0000_0005, 32'hfffc, 0);
        run(13, 32'h8000_0000, 32'h8000, 0);
        run(14, 32'h1234_9abc, 32'h0, 0);
        run(15, 32'h7fff_8001, 32'h0, 0);
        run(16, 32'h0000_fff7, 32'h0, 0);
        run(17, 32'h0000_ffff, 32'h0007, 0);
        run(17, 32'h0000_ffff, 32'h0002, 0);
        run(18, 32'hffff, 32'h0001, 0);
        run(19, 32'h8000_0000, 32'h7fff_ffff, 0);
        run(19, 32'hffff_ffff, 32'hffff, 1);
        run(25, 32'h1234, 32'h5678, 0);
        // Random traffic, with idle gaps where results must hold
        for (int i = 0; i < 400; i++) begin
            op = $urandom_range(19, 0);
            a = $urandom;
            b = $urandom;
            if (op == 5) begin
                b = $urandom_range(32767, 1);
                a = $urandom_range(b, 1);
            end
            if (op == 6 && a[15:0] == 16'h8000) a[0] = 1'b1;
            if (op >= 10 && op <= 13) b = $urandom_range(80, 0) - 40;
            run(op, a, b, 1'($urandom_range(1, 0)));
            if (i % 16 == 0) begin
                held = res_data;
                u_iss.idle();
                @(negedge ref_clk);
                check(res_valid === 1'b0 && res_data === held,
                      "result not held while idle");
            end
        end
        // Reset again mid-run; outputs must clear and traffic resume
        u_iss.idle();
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(res_valid === 1'b0 && res_sat === 1'b0
              && res_data === 32'h0, "mid-run reset state");
        sys_rst = 1'b0;
        run(0, 32'h8000, 32'h8000, 0);
        run(7, 32'h8000_0000, 32'h8000_0000, 0);
        conclude();
    end
endmodule : tb_top
